/* hw/pisr_top.sv */
/*
 Interrupt status block: serial register port, sticky flag registers,
 masks and summary. Assumes bus pins and monitor inputs are synchronous
 to core_clk_i and that the bus wire is resolved outside from the enable.
*/
`timescale 1ns/1ps
`include "pisr_defs.svh"

// Summary of operation
// - Summary bits 7,5,2 show pending groups
// - Summary bit 0 sticky button, write-one clears
// - Source bit 6 flags second battery detect
// - Source bit 5 flags first battery detect
// - Source bit 4 flags adapter detected
// - Source bit 3 flags die hot
// - Monitor bit 4 sets on adapter removal
// - Monitor bit 2 flags supply below threshold
// - Reset cause bit 5 flags button reset
// - Reset cause bit 4 flags regulator fault
// - Flag registers reset zero, reserved read zero
// - Mask bit per group flag, masked after reset; button flag has no mask
// - Second cause bit 1 flags critical temperature
module pisr_top
    import pisr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `PISR_I2C_DEV_ADDR
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Serial register bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_b_o,
    // Monitor inputs
    input wire pisr_monitor_type mon_i
);
    pisr_state_type state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] ptr, next_ptr;
    logic ack_on, next_ack_on;
    logic rw, next_rw;
    logic wr_q, next_wr;
    logic [7:0] wr_addr, next_wr_addr;
    logic [7:0] wr_data, next_wr_data;
    logic scl_q, sda_q, adp_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] rd_data, byte_in;
    logic [7:0] src_flags, mon_flags, rsta_flags, rstb_flags;
    logic [7:0] src_set, mon_set, rsta_set, rstb_set;
    logic [7:0] src_mask, mon_mask, rsta_mask, rstb_mask;
    logic [7:0] summary;
    logic btn_flag;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic [7:0] w1c(input logic wr, input logic [7:0] a,
                                       input logic [7:0] off, input logic [7:0] d,
                                       input logic [7:0] rw_mask);
        return (wr && hit(a, off)) ? (d & rw_mask) : 8'h00;
    endfunction

    // Bus line sampling; pins arrive already synchronous
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            adp_q <= 1'b0;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            adp_q <= mon_i.adapter_present_status;
        end
    end

    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;
    assign byte_in = {shreg[6:0], sda_i};

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_ack_on = ack_on;
        next_rw = rw;
        next_wr = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        if (stop_seen) begin
            next_state = ST_IDLE;
            next_ack_on = 1'b0;
        end else if (start_seen) begin
            next_state = ST_ADDR;
            next_cnt = 3'h0;
            next_ack_on = 1'b0;
        end else if (scl_rise) begin
            unique case (state)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    next_shreg = byte_in;
                    next_cnt = cnt + 3'h1;
                    if (cnt == 3'h7) begin
                        if (state == ST_ADDR) begin
                            next_rw = byte_in[0];
                            next_state = (byte_in[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                        end else if (state == ST_PTR) begin
                            next_ptr = byte_in;
                            next_state = ST_PTR_ACK;
                        end else begin
                            next_wr = 1'b1;
                            next_wr_addr = ptr;
                            next_wr_data = byte_in;
                            next_state = ST_WDATA_ACK;
                        end
                    end
                end
                ST_RDATA: begin
                    next_cnt = cnt + 3'h1;
                end
                ST_MACK: begin
                    // A missing acknowledge ends the read burst
                    if (sda_i) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_ack_on = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state)
                ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
                    next_ack_on = ~ack_on;
                    if (ack_on) begin
                        if (state == ST_ADDR_ACK && rw) begin
                            next_shreg = rd_data;
                            next_ptr = ptr + 8'h01;
                            next_state = ST_RDATA;
                        end else if (state == ST_ADDR_ACK) begin
                            next_state = ST_PTR;
                        end else if (state == ST_PTR_ACK) begin
                            next_state = ST_WDATA;
                        end else begin
                            next_ptr = ptr + 8'h01;
                            next_state = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    // The last bit stands through its high phase; turn over at its fall
                    next_shreg = {shreg[6:0], 1'b0};
                    next_state = (cnt == 3'h0) ? ST_MACK : ST_RDATA;
                end
                ST_MACK: begin
                    if (ack_on) begin
                        next_ack_on = 1'b0;
                        next_shreg = rd_data;
                        next_ptr = ptr + 8'h01;
                        next_state = ST_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            cnt <= 3'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            ack_on <= 1'b0;
            rw <= 1'b0;
            wr_q <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            ack_on <= next_ack_on;
            rw <= next_rw;
            wr_q <= next_wr;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_b_o = ~((ack_on && state != ST_MACK && state != ST_IDLE)
                          || (state == ST_RDATA && !shreg[7]));

    // Flags stay set while their condition lasts, so a clear cannot hide it
    always_comb begin
        src_set = 8'h00;
        mon_set = 8'h00;
        rsta_set = 8'h00;
        rstb_set = 8'h00;
        src_set[`PISR_SRC_BAT2] = mon_i.second_battery_detect;
        src_set[`PISR_SRC_BAT1] = mon_i.first_battery_detect;
        src_set[`PISR_SRC_ADP] = mon_i.adapter_present_event;
        src_set[`PISR_SRC_HOT] = mon_i.die_hot_event;
        mon_set[`PISR_MON_ADP_RM] = adp_q & ~mon_i.adapter_present_status;
        mon_set[`PISR_MON_VDC] = mon_i.critical_supply_low;
        rsta_set[`PISR_RSTA_BTN] = mon_i.button_forced_reset;
        rsta_set[`PISR_RSTA_VR] = mon_i.regulator_fault_reset;
        rstb_set[`PISR_RSTB_TEMP] = mon_i.critical_temperature_reset;
    end

    // Write-one clears; reserved positions can never set
    pisr_flag_cell #(.WIDTH(8)) u_src (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .set_i(src_set),
        .clr_i(w1c(wr_q, wr_addr, `PISR_OFF_SRC, wr_data, `PISR_SRC_RW)), .flag_o(src_flags)
    );
    pisr_flag_cell #(.WIDTH(8)) u_mon (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .set_i(mon_set),
        .clr_i(w1c(wr_q, wr_addr, `PISR_OFF_MON, wr_data, `PISR_MON_RW)), .flag_o(mon_flags)
    );
    pisr_flag_cell #(.WIDTH(8)) u_rsta (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .set_i(rsta_set),
        .clr_i(w1c(wr_q, wr_addr, `PISR_OFF_RSTA, wr_data, `PISR_RSTA_RW)), .flag_o(rsta_flags)
    );
    pisr_flag_cell #(.WIDTH(8)) u_rstb (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .set_i(rstb_set),
        .clr_i(w1c(wr_q, wr_addr, `PISR_OFF_RSTB, wr_data, `PISR_RSTB_RW)), .flag_o(rstb_flags)
    );
    pisr_flag_cell #(.WIDTH(1)) u_btn (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .flag_o(btn_flag),
        .set_i(mon_i.power_button_event),
        .clr_i(wr_q && hit(wr_addr, `PISR_OFF_SUMMARY) && wr_data[`PISR_SUM_BTN])
    );

    // Masks come up masked so no group flag reaches the summary unasked
    pisr_mask_reg #(.RESET_VAL(`PISR_SRC_MASK_RST), .RW_MASK(`PISR_SRC_RW)) u_src_m (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wdata_i(wr_data), .mask_o(src_mask),
        .wr_i(wr_q && hit(wr_addr, `PISR_OFF_SRC_MASK))
    );
    pisr_mask_reg #(.RESET_VAL(`PISR_MON_MASK_RST), .RW_MASK(`PISR_MON_RW)) u_mon_m (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wdata_i(wr_data), .mask_o(mon_mask),
        .wr_i(wr_q && hit(wr_addr, `PISR_OFF_MON_MASK))
    );
    pisr_mask_reg #(.RESET_VAL(`PISR_RSTA_MASK_RST), .RW_MASK(`PISR_RSTA_RW)) u_rsta_m (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wdata_i(wr_data), .mask_o(rsta_mask),
        .wr_i(wr_q && hit(wr_addr, `PISR_OFF_RSTA_MASK))
    );
    pisr_mask_reg #(.RESET_VAL(`PISR_RSTB_MASK_RST), .RW_MASK(`PISR_RSTB_RW)) u_rstb_m (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wdata_i(wr_data), .mask_o(rstb_mask),
        .wr_i(wr_q && hit(wr_addr, `PISR_OFF_RSTB_MASK))
    );

    always_comb begin
        summary = 8'h00;
        summary[`PISR_SUM_RESET] = |(rsta_flags & ~rsta_mask) | |(rstb_flags & ~rstb_mask);
        summary[`PISR_SUM_MON] = |(mon_flags & ~mon_mask);
        summary[`PISR_SUM_SRC] = |(src_flags & ~src_mask);
        summary[`PISR_SUM_BTN] = btn_flag;
    end

    // Unmapped offsets read zero
    always_comb begin
        unique case (ptr)
            `PISR_OFF_SUMMARY: rd_data = summary;
            `PISR_OFF_SRC: rd_data = src_flags;
            `PISR_OFF_MON: rd_data = mon_flags;
            `PISR_OFF_RSTA: rd_data = rsta_flags;
            `PISR_OFF_RSTB: rd_data = rstb_flags;
            `PISR_OFF_MON_MASK: rd_data = mon_mask;
            `PISR_OFF_SRC_MASK: rd_data = src_mask;
            `PISR_OFF_RSTA_MASK: rd_data = rsta_mask;
            `PISR_OFF_RSTB_MASK: rd_data = rstb_mask;
            default: rd_data = 8'h00;
        endcase
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    summary_groups_a: assert property (
        summary[`PISR_SUM_SRC] == |(src_flags & ~src_mask)
        && summary[`PISR_SUM_MON] == |(mon_flags & ~mon_mask)
        && summary[6] == 1'b0 && summary[1] == 1'b0)
        else $error("summary group bit wrong");
    button_hold_a: assert property (
        summary[`PISR_SUM_BTN] && !(wr_q && hit(wr_addr, `PISR_OFF_SUMMARY))
        |=> summary[`PISR_SUM_BTN])
        else $error("button flag lost without clear");
    button_set_a: assert property (
        mon_i.power_button_event |=> summary[`PISR_SUM_BTN])
        else $error("button flag not set");
    second_battery_a: assert property (
        mon_i.second_battery_detect |=> src_flags[`PISR_SRC_BAT2])
        else $error("second battery flag missing");
    first_battery_a: assert property (
        mon_i.first_battery_detect |=> src_flags[`PISR_SRC_BAT1])
        else $error("first battery flag missing");
    adapter_flag_a: assert property (
        mon_i.adapter_present_event |=> src_flags[`PISR_SRC_ADP])
        else $error("adapter flag missing");
    die_hot_a: assert property (
        mon_i.die_hot_event |=> src_flags[`PISR_SRC_HOT])
        else $error("hot flag missing");
    adapter_removed_a: assert property (
        $fell(mon_i.adapter_present_status) |=> mon_flags[`PISR_MON_ADP_RM])
        else $error("adapter removal not flagged");
    supply_low_a: assert property (
        mon_i.critical_supply_low |=> mon_flags[`PISR_MON_VDC])
        else $error("supply low flag missing");
    button_reset_a: assert property (
        mon_i.button_forced_reset |=> rsta_flags[`PISR_RSTA_BTN])
        else $error("button reset flag missing");
    regulator_fault_a: assert property (
        mon_i.regulator_fault_reset |=> rsta_flags[`PISR_RSTA_VR])
        else $error("regulator fault flag missing");
    reserved_zero_a: assert property (
        (src_flags & ~`PISR_SRC_RW) == 8'h00 && (mon_flags & ~`PISR_MON_RW) == 8'h00
        && (rsta_flags & ~`PISR_RSTA_RW) == 8'h00 && (rstb_flags & ~`PISR_RSTB_RW) == 8'h00)
        else $error("reserved flag bit set");
    crit_temp_a: assert property (
        mon_i.critical_temperature_reset |=> rstb_flags[`PISR_RSTB_TEMP])
        else $error("critical temperature flag missing");
    flag_clear_a: assert property (
        wr_q && hit(wr_addr, `PISR_OFF_SRC) && wr_data[`PISR_SRC_HOT]
        && !mon_i.die_hot_event |=> !src_flags[`PISR_SRC_HOT])
        else $error("write one did not clear flag");
endmodule

/* common/pisr_defs.svh */
/*
 Register offsets, field positions, write masks and reset values of the
 interrupt status block. Assumes inclusion before any module that uses it.
*/
`ifndef PISR_DEFS_SVH
`define PISR_DEFS_SVH

`define PISR_OFF_SUMMARY 8'h02
`define PISR_OFF_SRC 8'h04
`define PISR_OFF_MON 8'h05
`define PISR_OFF_RSTA 8'h08
`define PISR_OFF_RSTB 8'h09
`define PISR_OFF_MON_MASK 8'h0B
`define PISR_OFF_SRC_MASK 8'h0C
`define PISR_OFF_RSTA_MASK 8'h11
`define PISR_OFF_RSTB_MASK 8'h12

`define PISR_SUM_RESET 7
`define PISR_SUM_MON 5
`define PISR_SUM_SRC 2
`define PISR_SUM_BTN 0
`define PISR_SRC_BAT2 6
`define PISR_SRC_BAT1 5
`define PISR_SRC_ADP 4
`define PISR_SRC_HOT 3
`define PISR_MON_ADP_RM 4
`define PISR_MON_VDC 2
`define PISR_RSTA_BTN 5
`define PISR_RSTA_VR 4
`define PISR_RSTB_TEMP 1

`define PISR_SRC_RW 8'h78
`define PISR_MON_RW 8'h14
`define PISR_RSTA_RW 8'h30
`define PISR_RSTB_RW 8'h02

`define PISR_FLAGS_RST 8'h00
`define PISR_SRC_MASK_RST 8'h78
`define PISR_MON_MASK_RST 8'h14
`define PISR_RSTA_MASK_RST 8'h30
`define PISR_RSTB_MASK_RST 8'h02

// Arbitrary bus address, not tied to any product
`define PISR_I2C_DEV_ADDR 7'h30

`endif

/* common/pisr_pkg.sv */
/*
 Types of the interrupt status block: monitor input bundle and the
 serial register port states. Assumes nothing of its surroundings.
*/
package pisr_pkg;

    typedef struct packed {
        logic second_battery_detect;
        logic first_battery_detect;
        logic adapter_present_event;
        logic die_hot_event;
        logic adapter_present_status;
        logic critical_supply_low;
        logic button_forced_reset;
        logic regulator_fault_reset;
        logic critical_temperature_reset;
        logic power_button_event;
    } pisr_monitor_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PTR_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_MACK = 4'hC
    } pisr_state_type;

endpackage

/* hw/pisr_flag_cell.sv */
/*
 Vector of sticky flags: set by hardware, cleared by write-one.
 Assumes set and clear are single-cycle or level signals on core_clk_i.
*/
`timescale 1ns/1ps
module pisr_flag_cell #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Set and clear
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    // Flags
    output logic [WIDTH-1:0] flag_o
);
    logic [WIDTH-1:0] next_flag;

    // Set wins over clear so an event in the clearing cycle is kept
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            next_flag[i] = (flag_o[i] & ~clr_i[i]) | set_i[i];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_o <= '0;
        end else begin
            flag_o <= next_flag;
        end
    end
endmodule

/* hw/pisr_mask_reg.sv */
/*
 Software mask register with a write mask and reset value.
 Assumes a one-cycle write strobe on core_clk_i.
*/
`timescale 1ns/1ps
module pisr_mask_reg #(
    parameter logic [7:0] RESET_VAL = 8'hFF,
    parameter logic [7:0] RW_MASK = 8'hFF
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Write port
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    // Mask value
    output logic [7:0] mask_o
);
    logic [7:0] next_mask;

    always_comb begin
        next_mask = wr_i ? (wdata_i & RW_MASK) : mask_o;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_o <= RESET_VAL;
        end else begin
            mask_o <= next_mask;
        end
    end
endmodule

/* tb/pisr_host_model.sv */
/*
 Behavioural host on the serial register bus: START, STOP, byte transfers
 and register access tasks. Assumes a pull-up on the resolved data wire.
*/
`timescale 1ns/1ps
module pisr_host_model (
    // Clock
    input wire logic core_clk_i,
    // Bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_drv_b_o
);
    initial begin
        scl_o = 1'b1;
        sda_drv_b_o = 1'b1;
    end

    // Two core cycles a quarter keeps each bus phase at four cycles
    task automatic step();
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask

    task automatic start_cond();
        sda_drv_b_o = 1'b1;
        step();
        scl_o = 1'b1;
        step();
        sda_drv_b_o = 1'b0;
        step();
        scl_o = 1'b0;
        step();
    endtask

    task automatic stop_cond();
        sda_drv_b_o = 1'b0;
        step();
        scl_o = 1'b1;
        step();
        sda_drv_b_o = 1'b1;
        step();
    endtask

    // Data only changes while the clock line is low
    task automatic bit_xfer(input logic b, output logic r);
        sda_drv_b_o = b;
        step();
        scl_o = 1'b1;
        step();
        r = sda_i;
        step();
        scl_o = 1'b0;
        step();
    endtask

    task automatic byte_xfer(input logic [7:0] d, input logic ack_b, output logic [7:0] q,
                             output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
            q[i] = r;
        end
        bit_xfer(ack_b, r);
        ack = ~r;
    endtask

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                          output logic ok);
        logic [7:0] q;
        logic k0, k1, k2;
        start_cond();
        byte_xfer({a, 1'b0}, 1'b1, q, k0);
        byte_xfer(off, 1'b1, q, k1);
        byte_xfer(d, 1'b1, q, k2);
        stop_cond();
        ok = k0 & k1 & k2;
    endtask

    // Eight bytes from the pointer, the last one answered with a NACK
    task automatic rd_regs(input logic [6:0] a, input logic [7:0] off, output logic [7:0] q [8]);
        logic [7:0] t;
        logic k;
        start_cond();
        byte_xfer({a, 1'b0}, 1'b1, t, k);
        byte_xfer(off, 1'b1, t, k);
        start_cond();
        byte_xfer({a, 1'b1}, 1'b1, t, k);
        for (int i = 0; i < 8; i++) begin
            byte_xfer(8'hFF, i == 7, q[i], k);
        end
        stop_cond();
    endtask
endmodule

/* tb/pisr_top_tb.sv */
/*
 Self-checking bench of the interrupt status block: directed and random
 monitor events, reads and write-one clears. Assumes the host model.
*/
`timescale 1ns/1ps
`include "pisr_defs.svh"
module pisr_top_tb
    import pisr_pkg::*;
;
    localparam logic [6:0] ADDR = `PISR_I2C_DEV_ADDR;
    localparam int LIMIT = 98000;
    localparam logic [7:0] CLR_OFFS [5] = '{8'h02, 8'h04, 8'h05, 8'h08, 8'h09};
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    pisr_monitor_type mon = '0;
    logic scl, sda_drv_b, sda_dev, sda_oe_b, sda_wire;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 52038;
    logic [7:0] e_src = 8'h00, e_mon = 8'h00, e_ra = 8'h00, e_rb = 8'h00;
    logic e_btn = 1'b0;
    logic [7:0] m_mon = `PISR_MON_MASK_RST, m_src = `PISR_SRC_MASK_RST;
    logic [7:0] m_ra = `PISR_RSTA_MASK_RST, m_rb = `PISR_RSTB_MASK_RST;

    // Open-drain wire, pulled up when nobody pulls low
    assign sda_wire = sda_drv_b & (sda_oe_b | sda_dev);

    pisr_top dut_u (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .scl_i(scl),
        .sda_i(sda_wire),
        .sda_o(sda_dev),
        .sda_oe_b_o(sda_oe_b),
        .mon_i(mon)
    );

    pisr_host_model host_u (
        .core_clk_i(core_clk_i),
        .sda_i(sda_wire),
        .scl_o(scl),
        .sda_drv_b_o(sda_drv_b)
    );

    always #12.5 core_clk_i = ~core_clk_i;

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic [7:0] exp_at(input logic [7:0] off);
        case (off)
            8'h02: return {(|(e_ra & ~m_ra)) || (|(e_rb & ~m_rb)), 1'b0, |(e_mon & ~m_mon),
                           2'h0, |(e_src & ~m_src), 1'b0, e_btn};
            8'h04: return e_src;
            8'h05: return e_mon;
            8'h08: return e_ra;
            8'h09: return e_rb;
            8'h0B: return m_mon;
            8'h0C: return m_src;
            8'h11: return m_ra;
            8'h12: return m_rb;
            default: return 8'h00;
        endcase
    endfunction

    // Summary and group flag run first, then the mask registers
    task automatic check_all();
        logic [7:0] q [8];
        logic [7:0] base;
        for (int b = 0; b < 2; b++) begin
            base = b ? 8'h0B : 8'h02;
            host_u.rd_regs(ADDR, base, q);
            for (int i = 0; i < 8; i++) begin
                chk8($sformatf("reg %h", base + i), exp_at(base + 8'(i)), q[i]);
            end
        end
    endtask

    // Held one cycle; the status bit falls as the vector returns to zero
    task automatic apply_event(input pisr_monitor_type v);
        @(posedge core_clk_i);
        #1;
        mon = v;
        @(posedge core_clk_i);
        #1;
        mon = '0;
        e_src |= {1'b0, v.second_battery_detect, v.first_battery_detect,
                  v.adapter_present_event, v.die_hot_event, 3'h0};
        e_mon |= {3'h0, v.adapter_present_status, 1'b0, v.critical_supply_low, 2'h0};
        e_ra |= {2'h0, v.button_forced_reset, v.regulator_fault_reset, 4'h0};
        e_rb |= {6'h00, v.critical_temperature_reset, 1'b0};
        e_btn |= v.power_button_event;
    endtask

    // All ones also hit reserved and read-only bits, which must stay zero
    task automatic clear_all();
        logic ok;
        for (int i = 0; i < 5; i++) begin
            host_u.wr_reg(ADDR, CLR_OFFS[i], 8'hFF, ok);
            chk1("write ack", 1'b1, ok);
        end
        e_src = 8'h00;
        e_mon = 8'h00;
        e_ra = 8'h00;
        e_rb = 8'h00;
        e_btn = 1'b0;
    endtask

    task automatic set_masks(input logic [31:0] r);
        logic ok;
        host_u.wr_reg(ADDR, 8'h0B, r[7:0], ok);
        host_u.wr_reg(ADDR, 8'h0C, r[15:8], ok);
        host_u.wr_reg(ADDR, 8'h11, r[23:16], ok);
        host_u.wr_reg(ADDR, 8'h12, r[31:24], ok);
        m_mon = r[7:0] & `PISR_MON_RW;
        m_src = r[15:8] & `PISR_SRC_RW;
        m_ra = r[23:16] & `PISR_RSTA_RW;
        m_rb = r[31:24] & `PISR_RSTB_RW;
    endtask

    initial begin
        logic ok;
        logic [9:0] rv;
        logic [31:0] r;
        repeat (4) @(posedge core_clk_i);
        #1;
        rst_b_i = 1'b1;
        check_all();
        $display("test reset_values done");
        for (int i = 0; i < 10; i++) begin
            apply_event(10'h001 << i);
            check_all();
            clear_all();
        end
        $display("test single_events done");
        host_u.wr_reg(ADDR ^ 7'h01, 8'h0B, 8'h00, ok);
        chk1("foreign address ack", 1'b0, ok);
        check_all();
        $display("test foreign_address done");
        for (int n = 0; n < 8; n++) begin
            r = $random(seed);
            set_masks(r);
            rv = 10'($random(seed));
            apply_event(rv);
            check_all();
            clear_all();
        end
        check_all();
        $display("test random_events done");
        finish_test();
    end
endmodule
